// >>> common/mtc_regs.svh
// What this block does
// - six identical timer channels, each with a mode register selecting its mode
// - interval mode counts div1, div8, div32 or sub-clock div32 ticks
// - interval and event modes count down, reload on underflow, interrupt
// - programmed n gives one underflow per n plus one counted ticks
// - every mode counts only while its start flag is one
// - interval and event modes read back the live counter
// - data write while stopped loads reload register and counter
// - data write while running loads only reload, counter takes it at reload
// - event mode counts pin edges: rising, falling or both
// - event mode may count neighbour channel underflows or overflows instead
// - measurement mode counts up on the same four prescaled clocks
// - measurement edge copies counter to reload, restarts counter at zero
// - measurement edges interrupt, except the first edge after start
// - measurement overflow interrupts and sets the overflow flag together
// - mode register write while started clears the overflow flag
// - measurement mode reads the reload register, the latest result
// - measurement result undefined before the second edge after start
// - measurement mode ignores data register writes
`ifndef MTC_REGS_SVH
`define MTC_REGS_SVH

`define MTC_NCH 6
`define MTC_ADDR_W 8
// register byte addresses
`define MTC_START_ADDR 8'h00
`define MTC_STAT_ADDR 8'h04
`define MTC_MASK_ADDR 8'h08
`define MTC_CH_BASE 8'h10
`define MTC_CH_STRIDE 8'h08
`define MTC_CH_DATA_OFS 8'h04
// mode register fields
`define MTC_MODE_LSB 0
`define MTC_EDGE_LSB 2
`define MTC_SRC_BIT 4
`define MTC_OVF_BIT 5
`define MTC_CLK_LSB 6
// prescaler terminal counts
`define MTC_DIV8_MASK 3'h7
`define MTC_DIV32_TC 5'h1F
`define MTC_SUB32_TC 5'h1F
// reset values and counter maximum
`define MTC_MODE_RST 8'h00
`define MTC_CNT_RST 16'h0000
`define MTC_CNT_MAX 16'hFFFF

`endif

// >>> common/mtc_pkg.sv
`include "mtc_regs.svh"
package mtc_pkg;

	typedef enum logic [1:0] {
		MTC_INTERVAL,
		MTC_EVENT,
		MTC_MEASURE
	} mtc_mode_t;

	typedef enum logic [1:0] {
		MTC_CLK_DIV1,
		MTC_CLK_DIV8,
		MTC_CLK_DIV32,
		MTC_CLK_SUB32
	} mtc_clk_t;

	typedef struct packed {
		logic [7:0] mode;
		logic [15:0] cnt;
		logic [15:0] rld;
		logic ovf;
		logic seen;
		logic pin_q;
		logic evt;
	} mtc_ch_t;

	typedef struct packed {
		mtc_ch_t [`MTC_NCH-1:0] ch;
		logic [`MTC_NCH-1:0] start;
		logic [`MTC_NCH-1:0] stat;
		logic [`MTC_NCH-1:0] mask;
		logic [4:0] div;
		logic [4:0] sub;
		logic [31:0] rdata;
		logic irq;
	} mtc_state_t;

	typedef struct packed {
		logic [`MTC_ADDR_W-1:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} mtc_bus_t;

endpackage

// >>> rtl/mtc_timer.sv
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "mtc_regs.svh"
module mtc_timer (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire mtc_pkg::mtc_bus_t BUS,
	input wire logic SUBCLK_TICK,
	input wire logic [`MTC_NCH-1:0] EVENT_IN,
	output logic [31:0] RDATA,
	output logic IRQ
);
	import mtc_pkg::*;

	mtc_state_t s_r;
	mtc_state_t s_nxt;

	// ----------------------------------------
	// address decoding and tick selection
	// ----------------------------------------
	function automatic logic [`MTC_ADDR_W-1:0] ch_addr(input int idx,
		input logic data_reg);
		logic [`MTC_ADDR_W-1:0] a;
		a = `MTC_CH_BASE + `MTC_ADDR_W'(idx) * `MTC_CH_STRIDE;
		if (data_reg) begin
			a = a + `MTC_CH_DATA_OFS;
		end
		return a;
	endfunction

	function automatic logic pick_tick(input logic [1:0] sel,
		input logic t8, input logic t32, input logic tsub);
		logic t;
		case (mtc_clk_t'(sel))
			MTC_CLK_DIV1: t = 1'b1;
			MTC_CLK_DIV8: t = t8;
			MTC_CLK_DIV32: t = t32;
			MTC_CLK_SUB32: t = tsub;
			default: t = 1'b0;
		endcase
		return t;
	endfunction

	// ----------------------------------------
	// per-channel helpers
	// ----------------------------------------
	// channel i counts the events of channel i-1; channel 0 takes the last
	function automatic int neighbour(input int idx);
		int n;
		n = idx - 1;
		if (idx == 0) begin
			n = `MTC_NCH - 1;
		end
		return n;
	endfunction

	// effective edge for the event counter: rising, falling or both
	function automatic logic event_edge(input logic [1:0] sel,
		input logic rise, input logic fall);
		logic hit;
		case (sel)
			2'h0: begin
				hit = rise;
			end
			2'h1: begin
				hit = fall;
			end
			default: begin
				hit = rise || fall;
			end
		endcase
		return hit;
	endfunction

	// width sees every edge, period sees one polarity only
	function automatic logic measure_edge(input logic [1:0] sel,
		input logic rise, input logic fall);
		logic hit;
		if (sel[0]) begin
			hit = rise || fall;
		end else if (sel[1]) begin
			hit = fall;
		end else begin
			hit = rise;
		end
		return hit;
	endfunction

	// one step of the down counter; underflow reloads and flags evt
	function automatic mtc_ch_t count_down(input mtc_ch_t cur,
		input mtc_ch_t nxt, input logic run, input logic src);
		mtc_ch_t c;
		c = nxt;
		if (run && src) begin
			if (cur.cnt == `MTC_CNT_RST) begin
				c.cnt = cur.rld;
				c.evt = 1'b1;
			end else begin
				c.cnt = cur.cnt - 16'h0001;
			end
		end
		return c;
	endfunction

	// software data write in the down-counting modes
	function automatic mtc_ch_t data_load(input mtc_ch_t nxt,
		input logic run, input logic [15:0] wd);
		mtc_ch_t c;
		c = nxt;
		c.rld = wd;
		if (!run) begin
			c.cnt = wd;
		end
		return c;
	endfunction

	// one step of the measuring up counter; an edge beats a tick
	function automatic mtc_ch_t count_up(input mtc_ch_t cur,
		input mtc_ch_t nxt, input logic hit, input logic tick);
		mtc_ch_t c;
		c = nxt;
		if (hit) begin
			c.rld = cur.cnt;
			c.cnt = `MTC_CNT_RST;
			c.seen = 1'b1;
		end else if (tick) begin
			c.cnt = cur.cnt + 16'h0001;
			if (cur.cnt == `MTC_CNT_MAX) begin
				c.ovf = 1'b1;
				c.evt = 1'b1;
			end
		end
		return c;
	endfunction

	// mode register readback with the live overflow flag in place
	function automatic logic [31:0] mode_view(input mtc_ch_t cur);
		logic [31:0] v;
		v = {24'h000000, cur.mode};
		v[`MTC_OVF_BIT] = cur.ovf;
		return v;
	endfunction

	// data register readback: live count, or the latest result
	function automatic logic [31:0] data_view(input mtc_ch_t cur);
		logic [31:0] v;
		v = {16'h0000, cur.cnt};
		if (mtc_mode_t'(cur.mode[`MTC_MODE_LSB+:2]) == MTC_MEASURE) begin
			v = {16'h0000, cur.rld};
		end
		return v;
	endfunction

	// flag registers read back in the low bits
	function automatic logic [31:0] flag_view(
		input logic [`MTC_NCH-1:0] f);
		logic [31:0] v;
		v = 32'h0000_0000;
		v[`MTC_NCH-1:0] = f;
		return v;
	endfunction

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		mtc_ch_t c;
		logic t8;
		logic t32;
		logic tsub;
		logic tick;
		logic rise;
		logic fall;
		logic src;
		logic edge_hit;
		logic run;
		logic mode_wr;
		logic data_wr;
		logic [`MTC_NCH-1:0] set;
		logic [1:0] m;
		c = '0;
		tick = 1'b0;
		rise = 1'b0;
		fall = 1'b0;
		src = 1'b0;
		edge_hit = 1'b0;
		run = 1'b0;
		mode_wr = 1'b0;
		data_wr = 1'b0;
		m = 2'h0;
		set = '0;
		s_nxt = s_r;
		s_nxt.rdata = 32'h0000_0000;
		// shared prescaler and sub-clock divider
		s_nxt.div = s_r.div + 5'h01;
		t8 = (s_r.div[2:0] == `MTC_DIV8_MASK);
		t32 = (s_r.div == `MTC_DIV32_TC);
		tsub = SUBCLK_TICK && (s_r.sub == `MTC_SUB32_TC);
		if (SUBCLK_TICK) begin
			s_nxt.sub = s_r.sub + 5'h01;
		end
		// ----------------------------------------
		// shared registers
		// ----------------------------------------
		if (BUS.wr && BUS.addr == `MTC_START_ADDR) begin
			s_nxt.start = BUS.wdata[`MTC_NCH-1:0];
		end
		if (BUS.wr && BUS.addr == `MTC_MASK_ADDR) begin
			s_nxt.mask = BUS.wdata[`MTC_NCH-1:0];
		end
		if (BUS.rd && BUS.addr == `MTC_START_ADDR) begin
			s_nxt.rdata = flag_view(s_r.start);
		end
		if (BUS.rd && BUS.addr == `MTC_MASK_ADDR) begin
			s_nxt.rdata = flag_view(s_r.mask);
		end

		// ----------------------------------------
		// channel step
		// ----------------------------------------

		for (int i = 0; i < `MTC_NCH; i++) begin
			c = s_r.ch[i];
			c.evt = 1'b0;
			c.pin_q = EVENT_IN[i];
			m = s_r.ch[i].mode[`MTC_MODE_LSB+:2];
			run = s_r.start[i];
			mode_wr = BUS.wr && BUS.addr == ch_addr(i, 1'b0);
			data_wr = BUS.wr && BUS.addr == ch_addr(i, 1'b1);
			rise = EVENT_IN[i] && !s_r.ch[i].pin_q;
			fall = !EVENT_IN[i] && s_r.ch[i].pin_q;
			tick = pick_tick(s_r.ch[i].mode[`MTC_CLK_LSB+:2], t8, t32,
				tsub);

			// mode write first so an overflow this cycle wins
			if (mode_wr) begin
				c.mode = BUS.wdata[7:0];
				c.mode[`MTC_OVF_BIT] = 1'b0;
				if (run) begin
					c.ovf = 1'b0;
				end
			end

			case (mtc_mode_t'(m))
				MTC_INTERVAL, MTC_EVENT: begin
					if (mtc_mode_t'(m) == MTC_INTERVAL) begin
						src = tick;
					end else if (s_r.ch[i].mode[`MTC_SRC_BIT]) begin
						src = s_r.ch[neighbour(i)].evt;
					end else begin
						src = event_edge(s_r.ch[i].mode[`MTC_EDGE_LSB+:2],
							rise, fall);
					end
					c = count_down(s_r.ch[i], c, run, src);
					set[i] = c.evt;
					if (data_wr) begin
						c = data_load(c, run, BUS.wdata[15:0]);
					end
				end
				MTC_MEASURE: begin
					edge_hit = measure_edge(
						s_r.ch[i].mode[`MTC_EDGE_LSB+:2], rise, fall);
					if (run) begin
						c = count_up(s_r.ch[i], c, edge_hit, tick);
						set[i] = c.evt || (edge_hit && s_r.ch[i].seen);
					end
					// data writes are dropped here
				end
				default: begin
				end
			endcase
			if (!run) begin
				c.seen = 1'b0;
			end

			// ----------------------------------------
			// channel readback
			// ----------------------------------------
			if (BUS.rd && BUS.addr == ch_addr(i, 1'b0)) begin
				s_nxt.rdata = mode_view(s_r.ch[i]);
			end
			if (BUS.rd && BUS.addr == ch_addr(i, 1'b1)) begin
				s_nxt.rdata = data_view(s_r.ch[i]);
			end
			s_nxt.ch[i] = c;
		end

		// ----------------------------------------
		// interrupt status: read clears, new event wins
		// ----------------------------------------
		if (BUS.rd && BUS.addr == `MTC_STAT_ADDR) begin
			s_nxt.rdata = flag_view(s_r.stat);
			s_nxt.stat = '0;
		end
		s_nxt.stat = s_nxt.stat | set;
		s_nxt.irq = |(s_nxt.stat & s_nxt.mask);
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign RDATA = s_r.rdata;
	assign IRQ = s_r.irq;

endmodule

// >>> dv/mtc_timer_properties.sv
`timescale 1ns/1ps
module mtc_timer_properties (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire mtc_pkg::mtc_bus_t BUS,
	input wire logic [31:0] RDATA,
	input wire logic IRQ
);
	import mtc_pkg::*;
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	sequence s_wr_rd(a);
		BUS.wr && BUS.addr == a ##1 BUS.rd && BUS.addr == a;
	endsequence
	property p_rd_idle; !BUS.rd |=> RDATA == 32'h0; endproperty
	property p_upper; BUS.rd |=> RDATA[31:16] == 16'h0; endproperty
	property p_unmap; BUS.rd && BUS.addr == 8'h0C |=> RDATA == 32'h0;
	endproperty
	property p_start;
		s_wr_rd(8'h00) |=> RDATA[5:0] == $past(BUS.wdata[5:0], 2);
	endproperty
	property p_mask;
		s_wr_rd(8'h08) |=> RDATA[5:0] == $past(BUS.wdata[5:0], 2);
	endproperty
	property p_mode;
		s_wr_rd(8'h10) |=> RDATA[4:0] == $past(BUS.wdata[4:0], 2);
	endproperty
	property p_mask_off;
		BUS.wr && BUS.addr == 8'h08 && BUS.wdata[5:0] == 6'h0 |-> ##2 !IRQ;
	endproperty
	property p_rst; $fell(RST) |-> !IRQ && RDATA == 32'h0; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
	a_upper: assert property (p_upper) else $error("upper bits set");
	a_unmap: assert property (p_unmap) else $error("unmapped read");
	a_start: assert property (p_start) else $error("start readback");
	a_mask: assert property (p_mask) else $error("mask readback");
	a_mode: assert property (p_mode) else $error("mode readback");
	a_mask_off: assert property (p_mask_off) else $error("irq masked");
	a_rst: assert property (p_rst) else $error("reset outputs");
endmodule

// >>> dv/mtc_pulse_src.sv
`timescale 1ns/1ps
module mtc_pulse_src (
	input wire logic clk,
	output logic [5:0] pin
);
	initial pin = 6'h00;
	// one pulse: four low, rising edge, four cycles high, falling edge, four low
	task automatic pulse(input int ch);
		repeat (4) @(posedge clk);
		pin[ch] <= 1'b1;
		repeat (4) @(posedge clk);
		pin[ch] <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
endmodule

// >>> dv/mtc_timer_tb.sv
`timescale 1ns/1ps
module mtc_timer_tb;
	import mtc_pkg::*;
	logic clk, rst, sub_tick, irq;
	logic [5:0] ev;
	logic [31:0] rdata;
	mtc_bus_t bus;
	int n_mismatch = 0;
	int comparisons = 0;
	int cycles = 0;
	mtc_timer u_dut (.CORE_CLK(clk), .RST(rst), .BUS(bus),
		.SUBCLK_TICK(sub_tick), .EVENT_IN(ev), .RDATA(rdata), .IRQ(irq));
	mtc_pulse_src u_src (.clk(clk), .pin(ev));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		sub_tick <= (cycles[1:0] == 2'h3);
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	task give_verdict;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, e);
		comparisons++;
		if (seen !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, seen);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
		@(posedge clk);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge clk);
		bus.rd <= 1'b0;
		#1 chk(nm, rdata, e);
	endtask
	// write, then read back the same place in the very next cycle
	task wrc(input logic [7:0] a, input logic [31:0] d, e, input string nm);
		wr(a, d);
		bus.rd <= 1'b1;
		@(posedge clk);
		bus.rd <= 1'b0;
		#1 chk(nm, rdata, e);
	endtask
	task t_regs;
		wrc(8'h08, 32'h3F, 32'h3F, "mask");
		wrc(8'h10, 32'hF7, 32'hD7, "mode");
		wr(8'h0C, 32'h55);
		rdc(8'h0C, 32'h0, "unmapped");
		$display("t_regs done");
	endtask
	task t_event;
		wr(8'h18, 32'h01);
		wr(8'h1C, 32'h2);
		rdc(8'h1C, 32'h2, "stopped load");
		wrc(8'h00, 32'h02, 32'h02, "start");
		u_src.pulse(1);
		rdc(8'h1C, 32'h1, "live");
		wr(8'h1C, 32'h7);
		rdc(8'h1C, 32'h1, "running write");
		u_src.pulse(1);
		rdc(8'h04, 32'h0, "no underflow");
		u_src.pulse(1);
		chk("irq", {31'h0, irq}, 32'h1);
		rdc(8'h04, 32'h2, "underflow");
		chk("irq clear", {31'h0, irq}, 32'h0);
		rdc(8'h1C, 32'h7, "reload");
		wr(8'h00, 32'h0);
		u_src.pulse(1);
		rdc(8'h1C, 32'h7, "stopped");
		for (int e = 1; e < 3; e++) begin
			wr(8'h18, 32'h01 | 32'(e << 2));
			wr(8'h1C, 32'h1);
			wr(8'h00, 32'h02);
			u_src.pulse(1);
			rdc(8'h1C, (e == 2) ? 32'h1 : 32'h0, "edge");
			wr(8'h00, 32'h0);
		end
		rdc(8'h04, 32'h2, "both edges");
		$display("t_event done");
	endtask
	task t_meas;
		wr(8'h20, 32'h02);
		wr(8'h24, 32'h5);
		wr(8'h00, 32'h04);
		u_src.pulse(2);
		rdc(8'h04, 32'h0, "first edge");
		u_src.pulse(2);
		rdc(8'h04, 32'h4, "second edge");
		rdc(8'h24, 32'h0D, "period");
		wr(8'h08, 32'h0);
		$display("t_meas done");
	endtask
	task t_idle;
		wr(8'h00, 32'h0);
		wr(8'h34, 32'h9);
		for (int p = 0; p < 6; p++) begin
			u_src.pulse(p);
		end
		rdc(8'h34, 32'h9, "stopped ch4");
		rdc(8'h04, 32'h0, "no events");
		wr(8'h28, 32'hC0);
		wr(8'h2C, 32'h0);
		wr(8'h00, 32'h08);
		repeat (300) @(posedge clk);
		rdc(8'h04, 32'h8, "subclock");
		$display("t_idle done");
	endtask
	initial begin
		rst = 1'b1;
		bus = '0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_event();
		t_meas();
		t_idle();
		give_verdict();
	end
endmodule
bind mtc_timer mtc_timer_properties u_props (.CORE_CLK(CORE_CLK),
	.RST(RST), .BUS(BUS), .RDATA(RDATA), .IRQ(IRQ));
